//--- hw/clpm_master_regs.vh
// Constants for the current loop polling master
`ifndef CLPM_MASTER_REGS_VH
`define CLPM_MASTER_REGS_VH
// ----------------------------------------------------------------
// Message kinds
// ----------------------------------------------------------------
`define CLPM_K_POLL 3'h0
`define CLPM_K_CMD 3'h1
`define CLPM_K_ACK 3'h2
`define CLPM_K_REL 3'h3
// ----------------------------------------------------------------
// Baud rate selections and rates
// ----------------------------------------------------------------
`define CLPM_B110 3'h0
`define CLPM_B300 3'h1
`define CLPM_B600 3'h2
`define CLPM_B1200 3'h3
`define CLPM_B2400 3'h4
`define CLPM_RATE_110 110
`define CLPM_RATE_300 300
`define CLPM_RATE_600 600
`define CLPM_RATE_1200 1200
`define CLPM_RATE_2400 2400
// ----------------------------------------------------------------
// Counts, in bit times where timed, and the clock rate in Hz
// ----------------------------------------------------------------
`define CLPM_MAX_UNITS 240
`define CLPM_RETRIES 2'h3
`define CLPM_TIMEOUT_BITS 16'h0040
`define CLPM_LOOPBACK_BITS 16'h0100
`define CLPM_CLK_HZ 200000000
// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define CLPM_RST_ADDR 8'h01
`endif

//--- hw/clpm_master.v
// Current loop polling master: scan, commands, loop fault location
`timescale 1ns/100ps
`include "clpm_master_regs.vh"
`default_nettype none
module clpm_master #(
  parameter CLK_HZ    = `CLPM_CLK_HZ,
  parameter MAX_UNITS = `CLPM_MAX_UNITS
)(
  // Clock and reset
  input  wire       clk,
  input  wire       rst_n,
  // Configuration
  input  wire       side_primary,
  input  wire [2:0] baud_sel,
  input  wire [7:0] unit_count,
  // Command request
  input  wire       cmd_valid,
  input  wire [7:0] cmd_addr,
  input  wire [7:0] cmd_data,
  output reg        cmd_done,
  output reg        cmd_refused,
  // Message framer
  input  wire       tx_ready,
  output reg        tx_valid,
  output reg        tx_port_b,
  output reg  [2:0] tx_kind,
  output reg  [7:0] tx_addr,
  output reg  [7:0] tx_data,
  output reg        port_a_tx_en,
  output reg        port_b_tx_en,
  output reg [23:0] bit_div,
  input  wire       rx_valid,
  input  wire [7:0] rx_addr,
  input  wire [7:0] rx_data,
  input  wire       rx_new,
  input  wire       rx_dup,
  input  wire       echo_b,
  // Status
  output reg        rpt_valid,
  output reg  [7:0] rpt_addr,
  output reg  [7:0] rpt_data,
  output reg        unit_found,
  output reg        offline_valid,
  output reg        dup_valid,
  output reg  [7:0] evt_addr,
  output reg        loop_fault,
  output reg  [7:0] fault_pos_a,
  output reg  [7:0] fault_pos_b
);
  // ----------------------------------------------------------------
  // States
  // ----------------------------------------------------------------
  localparam S_IDLE  = 3'h0;
  localparam S_NEXT  = 3'h1;
  localparam S_WAIT  = 3'h2;
  localparam S_ACK   = 3'h3;
  localparam S_LOOP  = 3'h4;
  localparam S_REL   = 3'h5;
  localparam S_RWAIT = 3'h6;

  function [23:0] div_of;
    input [2:0]  sel;
    reg   [31:0] q;
    begin
      case (sel)
        `CLPM_B110:  q = CLK_HZ / `CLPM_RATE_110;
        `CLPM_B300:  q = CLK_HZ / `CLPM_RATE_300;
        `CLPM_B600:  q = CLK_HZ / `CLPM_RATE_600;
        `CLPM_B1200: q = CLK_HZ / `CLPM_RATE_1200;
        default:     q = CLK_HZ / `CLPM_RATE_2400;
      endcase
      div_of = q[23:0];
    end
  endfunction

  function [7:0] wrap_next;
    input [7:0] a;
    input [7:0] last;
    begin
      wrap_next = (a >= last) ? `CLPM_RST_ADDR : a + 8'h01;
    end
  endfunction

  reg   [2:0]         state;
  reg  [23:0]         bit_cnt;
  reg                 tick;
  reg  [15:0]         tmr;
  reg   [1:0]         tries;
  reg                 echo_seen;
  reg                 cur_cmd;
  reg   [7:0]         cur_addr;
  reg   [7:0]         scan_addr;
  reg   [7:0]         hop;
  reg   [7:0]         last_seen;
  reg                 rel_b;
  reg [MAX_UNITS:0]   present;
  reg [MAX_UNITS:0]   offline;
  reg [MAX_UNITS:0]   dup;
  reg [MAX_UNITS:0]   via_b;
  wire  [7:0]         last_addr;
  wire                reply;

  // Count clamp keeps the scan inside the supported population
  assign last_addr = (unit_count > MAX_UNITS) ? MAX_UNITS[7:0] : unit_count;
  assign reply     = rx_valid && (rx_addr == cur_addr);

  // ----------------------------------------------------------------
  // Bit time tick
  // ----------------------------------------------------------------
  always @(posedge clk)
  begin
    if (!rst_n)
    begin
      bit_cnt <= 24'h000000;
      tick    <= 1'b0;
      bit_div <= 24'h000000;
    end
    else
    begin
      bit_div <= div_of(baud_sel);
      tick    <= (bit_cnt + 24'h000001 >= bit_div);
      bit_cnt <= (bit_cnt + 24'h000001 >= bit_div) ? 24'h000000 : bit_cnt + 24'h000001;
    end
  end

  // ----------------------------------------------------------------
  // Scan, command and fault location sequencer
  // ----------------------------------------------------------------
  always @(posedge clk)
  begin
    cmd_done      <= 1'b0;
    cmd_refused   <= 1'b0;
    tx_valid      <= 1'b0;
    rpt_valid     <= 1'b0;
    unit_found    <= 1'b0;
    offline_valid <= 1'b0;
    dup_valid     <= 1'b0;
    if (!rst_n)
    begin
      state        <= S_IDLE;
      tmr          <= 16'h0000;
      tries        <= 2'h0;
      echo_seen    <= 1'b0;
      cur_cmd      <= 1'b0;
      cur_addr     <= `CLPM_RST_ADDR;
      scan_addr    <= `CLPM_RST_ADDR;
      hop          <= 8'h00;
      last_seen    <= 8'h00;
      rel_b        <= 1'b0;
      present      <= {(MAX_UNITS+1){1'b0}};
      offline      <= {(MAX_UNITS+1){1'b0}};
      dup          <= {(MAX_UNITS+1){1'b0}};
      via_b        <= {(MAX_UNITS+1){1'b0}};
      tx_port_b    <= 1'b0;
      tx_kind      <= `CLPM_K_POLL;
      tx_addr      <= 8'h00;
      tx_data      <= 8'h00;
      port_a_tx_en <= 1'b0;
      port_b_tx_en <= 1'b0;
      rpt_addr     <= 8'h00;
      rpt_data     <= 8'h00;
      evt_addr     <= 8'h00;
      loop_fault   <= 1'b0;
      fault_pos_a  <= 8'h00;
      fault_pos_b  <= 8'h00;
    end
    else
    begin
      if (tick && tmr != 16'h0000)
        tmr <= tmr - 16'h0001;
      if (!side_primary)
      begin
        state        <= S_IDLE;
        port_a_tx_en <= 1'b0;
        port_b_tx_en <= 1'b0;
      end
      else
      begin
        case (state)
          S_IDLE:
          begin
            port_a_tx_en <= 1'b1;
            port_b_tx_en <= loop_fault;
            state        <= S_NEXT;
          end
          S_NEXT:
          begin
            if (cmd_valid && dup[cmd_addr])
              cmd_refused <= 1'b1;
            else if (tx_ready)
            begin
              cur_cmd   <= cmd_valid;
              cur_addr  <= cmd_valid ? cmd_addr : scan_addr;
              tx_kind   <= cmd_valid ? `CLPM_K_CMD : `CLPM_K_POLL;
              tx_addr   <= cmd_valid ? cmd_addr : scan_addr;
              tx_data   <= cmd_valid ? cmd_data : 8'h00;
              tx_port_b <= loop_fault && via_b[cmd_valid ? cmd_addr : scan_addr];
              tx_valid  <= 1'b1;
              echo_seen <= 1'b0;
              tries     <= 2'h0;
              tmr       <= `CLPM_TIMEOUT_BITS;
              state     <= S_WAIT;
            end
          end
          S_WAIT:
          begin
            if (loop_fault && echo_seen && !tx_port_b)
            begin
              loop_fault <= 1'b0;
              via_b      <= {(MAX_UNITS+1){1'b0}};
              port_b_tx_en <= 1'b0;
            end
            if (reply)
            begin
              if (!loop_fault && !echo_seen)
                state <= S_LOOP;
              else
              begin
                offline[cur_addr] <= 1'b0;
                present[cur_addr] <= 1'b1;
                unit_found        <= !present[cur_addr];
                evt_addr          <= cur_addr;
                if (rx_dup)
                begin
                  dup[cur_addr] <= 1'b1;
                  dup_valid     <= 1'b1;
                end
                cmd_done <= cur_cmd;
                if (!cur_cmd)
                  scan_addr <= wrap_next(scan_addr, last_addr);
                rpt_valid <= rx_new;
                rpt_addr  <= cur_addr;
                rpt_data  <= rx_data;
                state     <= rx_new ? S_ACK : S_NEXT;
              end
            end
            else if (tmr == 16'h0000)
            begin
              if (!loop_fault && !echo_seen)
                state <= S_LOOP;
              else if (tries != `CLPM_RETRIES)
              begin
                if (tx_ready)
                begin
                  tries     <= tries + 2'h1;
                  tx_valid  <= 1'b1;
                  echo_seen <= 1'b0;
                  tmr       <= `CLPM_TIMEOUT_BITS;
                end
              end
              else
              begin
                offline[cur_addr] <= 1'b1;
                offline_valid     <= !offline[cur_addr];
                evt_addr          <= cur_addr;
                if (!cur_cmd)
                  scan_addr <= wrap_next(scan_addr, last_addr);
                state <= S_NEXT;
              end
            end
          end
          S_ACK:
          begin
            if (tx_ready)
            begin
              tx_kind  <= `CLPM_K_ACK;
              tx_valid <= 1'b1;
              state    <= S_NEXT;
            end
          end
          S_LOOP:
          begin
            if (port_a_tx_en)
            begin
              port_a_tx_en <= 1'b0;
              port_b_tx_en <= 1'b0;
              tmr          <= `CLPM_LOOPBACK_BITS;
            end
            else if (tmr == 16'h0000)
            begin
              port_a_tx_en <= 1'b1;
              rel_b        <= 1'b0;
              hop          <= `CLPM_RST_ADDR;
              last_seen    <= 8'h00;
              via_b        <= {(MAX_UNITS+1){1'b0}};
              state        <= S_REL;
            end
          end
          S_REL:
          begin
            if (tx_ready)
            begin
              tx_kind   <= `CLPM_K_REL;
              tx_addr   <= hop;
              tx_data   <= 8'h00;
              tx_port_b <= rel_b;
              tx_valid  <= 1'b1;
              tmr       <= `CLPM_TIMEOUT_BITS;
              state     <= S_RWAIT;
            end
          end
          S_RWAIT:
          begin
            if (rx_valid)
            begin
              last_seen       <= rx_addr;
              via_b[rx_addr]  <= rel_b;
              offline[rx_addr] <= 1'b0;
              hop             <= hop + 8'h01;
              state           <= (hop >= last_addr) ? S_RWAIT : S_REL;
              tmr             <= (hop >= last_addr) ? 16'h0000 : tmr;
            end
            else if (tmr == 16'h0000)
            begin
              if (!rel_b)
              begin
                fault_pos_a  <= last_seen;
                rel_b        <= 1'b1;
                port_b_tx_en <= 1'b1;
                hop          <= `CLPM_RST_ADDR;
                last_seen    <= 8'h00;
                state        <= S_REL;
              end
              else
              begin
                fault_pos_b <= last_seen;
                loop_fault  <= 1'b1;
                state       <= S_NEXT;
              end
            end
          end
          default:
            state <= S_IDLE;
        endcase
      end
      if (echo_b)
        echo_seen <= 1'b1;
    end
  end
endmodule
`default_nettype wire

//--- sim/clpm_master_properties.sv
// Assertion checker for the current loop polling master
`timescale 1ns/100ps
`include "clpm_master_regs.vh"
`default_nettype none
module clpm_master_properties #(
  parameter CLK_HZ    = `CLPM_CLK_HZ,
  parameter MAX_UNITS = `CLPM_MAX_UNITS
)(
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  // Watched ports
  input  wire logic        side_primary,
  input  wire logic [2:0]  baud_sel,
  input  wire logic        cmd_valid,
  input  wire logic [7:0]  cmd_addr,
  input  wire logic        cmd_done,
  input  wire logic        cmd_refused,
  input  wire logic        tx_ready,
  input  wire logic        tx_valid,
  input  wire logic        tx_port_b,
  input  wire logic [2:0]  tx_kind,
  input  wire logic [7:0]  tx_addr,
  input  wire logic        port_a_tx_en,
  input  wire logic        port_b_tx_en,
  input  wire logic [23:0] bit_div,
  input  wire logic        rx_valid,
  input  wire logic [7:0]  rx_addr,
  input  wire logic        loop_fault
);
  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  localparam int RATE[5] = '{110, 300, 600, 1200, 2400};
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  chk_ready_gate: assert property (tx_valid |-> $past(tx_ready))
    else $error("message issued without framer ready");
  chk_standby_quiet: assert property (!side_primary [*3] |->
    !tx_valid && !port_a_tx_en && !port_b_tx_en) else $error("standby side drives loop");
  chk_refuse_cause: assert property (cmd_refused |-> $past(cmd_valid) && !cmd_done)
    else $error("refusal without command");
  chk_done_source: assert property (cmd_done |->
    $past(rx_valid) && $past(rx_addr) == $past(cmd_addr)) else $error("done without reply");
  chk_port_a_send: assert property (tx_valid && !tx_port_b |-> port_a_tx_en)
    else $error("port A send while disabled");
  chk_port_b_send: assert property (tx_valid && tx_port_b |-> port_b_tx_en)
    else $error("port B send while disabled");
  chk_poll_range: assert property (tx_valid && tx_kind == `CLPM_K_POLL |->
    tx_addr != 8'h00 && tx_addr <= MAX_UNITS) else $error("poll address out of range");
  chk_rate_div: assert property (rst_n ##1 $stable(baud_sel) [*2] |->
    bit_div == 24'(CLK_HZ / RATE[baud_sel > 3'h4 ? 3'h4 : baud_sel])) else $error("bad divider");
  chk_silence_hold: assert property ($fell(port_a_tx_en) && side_primary &&
    $past(side_primary) |-> (!port_a_tx_en && !port_b_tx_en) [*8])
    else $error("silence too short");
  cov_cmd_done: cover property (cmd_done);
  cov_refused: cover property (cmd_refused);
  cov_fault: cover property ($rose(loop_fault));
endmodule
bind clpm_master clpm_master_properties #(.CLK_HZ(CLK_HZ), .MAX_UNITS(MAX_UNITS)) chk (
  .clk, .rst_n, .side_primary, .baud_sel, .cmd_valid, .cmd_addr, .cmd_done, .cmd_refused,
  .tx_ready, .tx_valid, .tx_port_b, .tx_kind, .tx_addr, .port_a_tx_en, .port_b_tx_en,
  .bit_div, .rx_valid, .rx_addr, .loop_fault);
`default_nettype wire

//--- sim/clpm_loop_model.sv
// Behavioural chain of field units on the loop
`timescale 1ns/100ps
`include "clpm_master_regs.vh"
`default_nettype none
module clpm_loop_model #(
  parameter N = 5
)(
  // Clock and loop setup
  input  wire logic        clk,
  input  wire logic [7:0]  brk,
  input  wire logic [7:0]  dup_addr,
  input  wire logic [7:0]  lat,
  input  wire logic [15:0] news,
  // Master side
  input  wire logic        tx_valid,
  input  wire logic        tx_port_b,
  input  wire logic [2:0]  tx_kind,
  input  wire logic [7:0]  tx_addr,
  output logic             rx_valid,
  output logic [7:0]       rx_addr,
  output logic [7:0]       rx_data,
  output logic             rx_new,
  output logic             rx_dup,
  output logic             echo_b
);
  // ----------------------------------------------------------------
  // Units answer only after a request
  // ----------------------------------------------------------------
  logic [7:0]  cnt   = 8'h00;
  logic [7:0]  who   = 8'h00;
  logic        pb    = 1'b0;
  logic [15:0] acked = 16'h0000;
  initial {rx_valid, rx_addr, rx_data, rx_new, rx_dup, echo_b} = 20'h00000;
  always @(posedge clk)
  begin
    rx_valid <= 1'b0;
    echo_b   <= 1'b0;
    // Idle reply lines do not keep the last value
    {rx_addr, rx_data, rx_new, rx_dup} <= ~{rx_addr, rx_data, rx_new, rx_dup};
    if (tx_valid)
    begin
      echo_b <= !tx_port_b && brk == 8'h00;
      who    <= (tx_kind == `CLPM_K_REL && tx_port_b) ? 8'(N + 1) - tx_addr : tx_addr;
      pb     <= tx_port_b;
      cnt    <= (tx_kind == `CLPM_K_ACK) ? 8'h00 : lat;
      if (tx_kind == `CLPM_K_ACK)
        acked[tx_addr[3:0]] <= 1'b1;
    end
    else if (cnt != 8'h00)
    begin
      cnt <= cnt - 8'h01;
      // A break hides units past it; they stay reachable from the other port
      if (cnt == 8'h01 && who != 8'h00 && who <= N &&
          (brk == 8'h00 || (pb ? who > brk : who <= brk)))
      begin
        rx_valid <= 1'b1;
        rx_addr  <= who;
        rx_data  <= who ^ 8'hA5;
        rx_new   <= news[who[3:0]] & ~acked[who[3:0]];
        rx_dup   <= who == dup_addr;
      end
    end
  end
endmodule
`default_nettype wire

//--- sim/current_loop_polling_master_bench.sv
// Self-checking bench for the current loop polling master
`timescale 1ns/100ps
`include "clpm_master_regs.vh"
`default_nettype none
module current_loop_polling_master_bench;
  localparam int HZ = 24000;
  localparam int RATES[5] = '{110, 300, 600, 1200, 2400};
  logic        clk, rst_n, side_primary, cmd_valid, tx_ready, tx_valid, tx_port_b, ordered;
  logic        cmd_done, cmd_refused, port_a_tx_en, port_b_tx_en, rx_valid, rx_new, rx_dup;
  logic        echo_b, rpt_valid, unit_found, offline_valid, dup_valid, loop_fault;
  logic [2:0]  baud_sel, tx_kind;
  logic [7:0]  unit_count, cmd_addr, cmd_data, tx_addr, tx_data, rx_addr, rx_data, rpt_addr;
  logic [7:0]  rpt_data, evt_addr, fault_pos_a, fault_pos_b, brk, dup, lat, last_poll, nxt;
  logic [15:0] news;
  logic [23:0] bit_div;
  logic [7:0]  exp_a;
  logic [7:0]  rq[$], aq[$];
  int          n_mismatch, cmp_count, n_found, n_rpt, n_resend, n_cmdtx, n_early, n_tx;
  clpm_master #(.CLK_HZ(HZ)) dut (
    .clk, .rst_n, .side_primary, .baud_sel, .unit_count, .cmd_valid, .cmd_addr, .cmd_data,
    .cmd_done, .cmd_refused, .tx_ready, .tx_valid, .tx_port_b, .tx_kind, .tx_addr, .tx_data,
    .port_a_tx_en, .port_b_tx_en, .bit_div, .rx_valid, .rx_addr, .rx_data, .rx_new, .rx_dup,
    .echo_b, .rpt_valid, .rpt_addr, .rpt_data, .unit_found, .offline_valid, .dup_valid,
    .evt_addr, .loop_fault, .fault_pos_a, .fault_pos_b);
  clpm_loop_model lm (
    .clk, .brk, .dup_addr(dup), .lat, .news, .tx_valid, .tx_port_b, .tx_kind, .tx_addr,
    .rx_valid, .rx_addr, .rx_data, .rx_new, .rx_dup, .echo_b);
  // ----------------------------------------------------------------
  // Checking and waiting
  // ----------------------------------------------------------------
  task automatic check(input logic [23:0] seen, input logic [23:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic summarize;
    if (n_mismatch == 0 && cmp_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  function automatic logic sig(input int s);
    case (s)
      0: return cmd_done;
      1: return cmd_refused;
      2: return offline_valid;
      3: return dup_valid;
      4: return loop_fault;
      default: return !loop_fault;
    endcase
  endfunction
  task automatic wait_sig(input int s, input int lim);
    int i = 0;
    while (sig(s) !== 1'b1 && i < lim)
    begin
      @(posedge clk);
      #1;
      i++;
    end
    check(sig(s), 1'b1);
    if (sig(s) !== 1'b1)
      summarize();
  endtask
  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  always @(posedge clk)
  begin
    #1;
    tx_ready = ($urandom % 4) != 0;
    lat = 8'h02 + 8'($urandom % 30);
  end
  // ----------------------------------------------------------------
  // Reference model of scan, reports and acknowledges
  // ----------------------------------------------------------------
  always @(posedge clk)
    if (rst_n === 1'b1)
    begin
      if (rx_valid && rx_new)
      begin
        rq.push_back(rx_addr);
        aq.push_back(rx_addr);
      end
      if (rpt_valid === 1'b1)
      begin
        n_rpt++;
        exp_a = rq.size() != 0 ? rq.pop_front() : 8'hFF;
        check(rpt_addr, exp_a);
        check(rpt_data, exp_a ^ 8'hA5);
      end
      if (unit_found === 1'b1)
        n_found++;
      if (tx_valid === 1'b1)
        n_tx++;
      if (tx_valid === 1'b1 && tx_kind === `CLPM_K_ACK)
        check(tx_addr, aq.size() != 0 ? aq.pop_front() : 8'hFF);
      if (tx_valid === 1'b1 && tx_kind === `CLPM_K_CMD)
      begin
        n_cmdtx++;
        check({tx_addr, tx_data}, {cmd_addr, cmd_data});
      end
      if (tx_valid === 1'b1 && loop_fault === 1'b1)
        check(tx_port_b, tx_addr > 8'h02);
      if (tx_valid === 1'b1 && tx_kind === `CLPM_K_POLL)
      begin
        check(tx_data, 8'h00);
        n_early += cmd_valid;
        if (tx_addr === last_poll)
          n_resend++;
        else if (ordered)
          check(tx_addr, nxt);
        last_poll = tx_addr;
        nxt = tx_addr % unit_count + 8'h01;
      end
    end
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  initial
  begin
    void'($urandom(32'hA92D));
    {rst_n, side_primary, cmd_valid, ordered} = 4'h1;
    {baud_sel, unit_count, cmd_addr, cmd_data, brk, dup} = {3'h0, 8'h05, 32'h0};
    {news, last_poll, nxt} = {16'h0014, 8'h00, 8'h01};
    repeat (3) @(posedge clk);
    #1 rst_n = 1'b1;
    for (int s = 0; s < 5; s++)
    begin
      baud_sel = s[2:0];
      repeat (4) @(posedge clk);
      #1 check(bit_div, HZ / RATES[s]);
    end
    check(n_tx, 0);
    side_primary = 1'b1;
    for (int i = 0; i < 20000 && n_found < 5; i++)
      @(posedge clk);
    repeat (800) @(posedge clk);
    #1 check(n_found, 5);
    check(n_rpt, 2);
    check(aq.size(), 0);
    for (int c = 0; c < 3; c++)
    begin
      cmd_addr = 8'h01 + 8'($urandom % 5);
      cmd_data = 8'($urandom);
      n_early = 0;
      cmd_valid = 1'b1;
      wait_sig(0, 3000);
      cmd_valid = 1'b0;
      check(n_early <= 1, 1'b1);
      @(posedge clk) #1;
    end
    check(n_cmdtx, 3);
    ordered = 1'b0;
    dup = 8'h03;
    wait_sig(3, 3000);
    check(evt_addr, 3);
    cmd_addr = 8'h03;
    cmd_valid = 1'b1;
    wait_sig(1, 400);
    cmd_valid = 1'b0;
    check(n_cmdtx, 3);
    dup = 8'h00;
    unit_count = 8'h06;
    n_resend = 0;
    wait_sig(2, 8000);
    check(evt_addr, 6);
    check(n_resend, 3);
    unit_count = 8'h05;
    brk = 8'h02;
    wait_sig(4, 15000);
    check(fault_pos_a, 2);
    check(fault_pos_b, 3);
    check(port_b_tx_en, 1'b1);
    // Keep the break a while so units beyond it are polled from port B
    repeat (300) @(posedge clk);
    #1 brk = 8'h00;
    wait_sig(5, 4000);
    repeat (2) @(posedge clk);
    #1 check(port_b_tx_en, 1'b0);
    check(port_a_tx_en, 1'b1);
    summarize();
  end
endmodule
`default_nettype wire
